//--- rtl/ppio_pkg.sv
package ppio_pkg;
    // Register byte offsets, one aligned word each
    localparam logic [3:0] OFS_PORT_A = 4'h0;
    localparam logic [3:0] OFS_PORT_B = 4'h4;
    localparam logic [3:0] OFS_HANDSHAKE = 4'h8;
    localparam logic [3:0] OFS_MODE = 4'hC;
    localparam logic [7:0] MODE_RESET = 8'h9B;
    // Mode word fields
    localparam int MW_FLAG = 7;
    localparam int MW_A_HI = 6;
    localparam int MW_A_LO = 5;
    localparam int MW_A_IN = 4;
    localparam int MW_CU_IN = 3;
    localparam int MW_B_M1 = 2;
    localparam int MW_B_IN = 1;
    localparam int MW_CL_IN = 0;
    localparam logic [1:0] GA_MODE1 = 2'h1;
    // Handshake port line positions
    localparam int C_OBF_A = 7;
    localparam int C_ACK_A = 6;
    localparam int C_IBF_A = 5;
    localparam int C_STB_A = 4;
    localparam int C_IRQ_A = 3;
    localparam int C_HS_B = 2;
    localparam int C_FULL_B = 1;
    localparam int C_IRQ_B = 0;
    // Line masks per group setting
    localparam logic [7:0] HS_A_IN = 8'h38;
    localparam logic [7:0] HS_A_OUT = 8'hC8;
    localparam logic [7:0] HS_B = 8'h07;
    localparam logic [7:0] DRV_A_IN = 8'h28;
    localparam logic [7:0] DRV_A_OUT = 8'h88;
    localparam logic [7:0] DRV_B = 8'h03;
    // Typical mode words
    localparam logic [7:0] CW_ALL_OUT = 8'h80;
    localparam logic [7:0] CW_A_IN = 8'h90;
    localparam logic [7:0] CW_B_IN = 8'h82;
    localparam logic [7:0] CW_C_IN = 8'h89;
    localparam logic [7:0] CW_A_STB_IN = 8'hB0;
    localparam logic [7:0] CW_B_STB_IN = 8'h86;
    localparam logic [7:0] CW_A_STB_OUT = 8'hA0;
    localparam logic [7:0] CW_B_STB_OUT = 8'h84;

    // Avalon-MM request from the master
    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } avs_req_t;

    // Whole state of the port block
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] lat_a;
        logic [7:0] lat_b;
        logic [7:0] lat_c;
        logic [7:0] in_a;
        logic [7:0] in_b;
        logic port_a_input_full;
        logic port_b_input_full;
        logic port_a_output_full_n;
        logic port_b_output_full_n;
        logic [7:0] s1_a;
        logic [7:0] s2_a;
        logic [7:0] s1_b;
        logic [7:0] s2_b;
        logic [7:0] s1_c;
        logic [7:0] s2_c;
        logic [7:0] prev_c;
        logic waitreq;
        logic [31:0] rdata;
        logic [7:0] pa_out;
        logic [7:0] pa_oe;
        logic [7:0] pb_out;
        logic [7:0] pb_oe;
        logic [7:0] pc_out;
        logic [7:0] pc_oe;
    } ppio_state_t;
endpackage

//--- rtl/strobed_parallel_io_ports.sv
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Word 80: all three ports drive outputs
// - Word 90: A input, B and C output
// - Word 82: B input, A and C output
// - Word 89: C input, A and B output
// - Mode 1: data port plus three port C lines per group
// - Mode 1 transfers paced by strobe/ack handshakes
// - Word B0: port A strobed input
// - Word 86: port B strobed input
// - Strobe latches A, sets full bit 5
// - Strobe latches B, sets full bit 1
// - A strobed input leaves lines 6,7 free
// - A strobed output leaves lines 4,5 free
// - B strobed mode leaves line 3 spare unless A is strobed
// - Input and output status layouts differ
// - Bit 7 set means configuration word
// - Mode 0 outputs latched, inputs live
// - Word A0: port A strobed output
// - Word 84: port B strobed output
module strobed_parallel_io_ports (
    input wire logic mclk,
    input wire logic rstn,
    input wire ppio_pkg::avs_req_t avs_req,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] pa_in,
    output logic [7:0] pa_out,
    output logic [7:0] pa_oe,
    input wire logic [7:0] pb_in,
    output logic [7:0] pb_out,
    output logic [7:0] pb_oe,
    input wire logic [7:0] pc_in,
    output logic [7:0] pc_out,
    output logic [7:0] pc_oe
);
    ppio_pkg::ppio_state_t st;
    ppio_pkg::ppio_state_t next_st;

    // Decoded configuration and handshake view
    logic ga_m1, a_in, gb_m1, b_in, irq_a, irq_b, req, take;
    logic fall_stb_a, fall_stb_b, fall_ack_a, fall_ack_b;
    logic [7:0] hs_mask, drv_mask, gp_in, stat, rd_c;

    // Mode word fields steer every group
    always_comb begin
        ga_m1 = st.mode[ppio_pkg::MW_A_HI:ppio_pkg::MW_A_LO] == ppio_pkg::GA_MODE1;
        gb_m1 = st.mode[ppio_pkg::MW_B_M1];
        a_in = st.mode[ppio_pkg::MW_A_IN];
        b_in = st.mode[ppio_pkg::MW_B_IN];
        irq_a = a_in ? st.port_a_input_full & st.lat_c[ppio_pkg::C_STB_A]
                     : st.port_a_output_full_n & st.lat_c[ppio_pkg::C_ACK_A];
        irq_b = b_in ? st.port_b_input_full & st.lat_c[ppio_pkg::C_HS_B]
                     : st.port_b_output_full_n & st.lat_c[ppio_pkg::C_HS_B];
        // Falling edges of synchronised strobe and acknowledge lines
        fall_stb_a = ga_m1 & a_in & st.prev_c[ppio_pkg::C_STB_A]
                     & ~st.s2_c[ppio_pkg::C_STB_A];
        fall_ack_a = ga_m1 & ~a_in & st.prev_c[ppio_pkg::C_ACK_A]
                     & ~st.s2_c[ppio_pkg::C_ACK_A];
        fall_stb_b = gb_m1 & b_in & st.prev_c[ppio_pkg::C_HS_B] & ~st.s2_c[ppio_pkg::C_HS_B];
        fall_ack_b = gb_m1 & ~b_in & st.prev_c[ppio_pkg::C_HS_B] & ~st.s2_c[ppio_pkg::C_HS_B];
    end

    // Handshake line masks and status word
    always_comb begin
        hs_mask = 8'h00;
        drv_mask = 8'h00;
        stat = 8'h00;
        if (ga_m1) begin
            hs_mask = a_in ? ppio_pkg::HS_A_IN : ppio_pkg::HS_A_OUT;
            drv_mask = a_in ? ppio_pkg::DRV_A_IN : ppio_pkg::DRV_A_OUT;
            stat[ppio_pkg::C_IRQ_A] = irq_a;
            if (a_in) begin
                stat[ppio_pkg::C_IBF_A] = st.port_a_input_full;
                stat[ppio_pkg::C_STB_A] = st.lat_c[ppio_pkg::C_STB_A];
            end else begin
                stat[ppio_pkg::C_OBF_A] = st.port_a_output_full_n;
                stat[ppio_pkg::C_ACK_A] = st.lat_c[ppio_pkg::C_ACK_A];
            end
        end
        if (gb_m1) begin
            hs_mask = hs_mask | ppio_pkg::HS_B;
            drv_mask = drv_mask | ppio_pkg::DRV_B;
            stat[ppio_pkg::C_HS_B] = st.lat_c[ppio_pkg::C_HS_B];
            stat[ppio_pkg::C_FULL_B] = b_in ? st.port_b_input_full
                                            : st.port_b_output_full_n;
            stat[ppio_pkg::C_IRQ_B] = irq_b;
        end
        gp_in = ~hs_mask & {{4{st.mode[ppio_pkg::MW_CU_IN]}}, {4{st.mode[ppio_pkg::MW_CL_IN]}}};
        rd_c = (hs_mask & stat) | (gp_in & st.s2_c) | (~hs_mask & ~gp_in & st.lat_c);
    end

    // Avalon handshake: one wait cycle, then accept
    always_comb begin
        req = avs_req.read | avs_req.write;
        take = req & ~st.waitreq;
    end

    // Next state of the whole block
    always_comb begin
        next_st = st;
        next_st.s1_a = pa_in;
        next_st.s2_a = st.s1_a;
        next_st.s1_b = pb_in;
        next_st.s2_b = st.s1_b;
        next_st.s1_c = pc_in;
        next_st.s2_c = st.s1_c;
        next_st.prev_c = st.s2_c;
        next_st.waitreq = ~(req & st.waitreq);
        // Read data prepared during the wait cycle
        if (req & st.waitreq) begin
            unique case (avs_req.address)
                ppio_pkg::OFS_PORT_A: next_st.rdata = {24'h000000, ga_m1 ? st.in_a
                    : (a_in ? st.s2_a : st.lat_a)};
                ppio_pkg::OFS_PORT_B: next_st.rdata = {24'h000000, gb_m1 ? st.in_b
                    : (b_in ? st.s2_b : st.lat_b)};
                ppio_pkg::OFS_HANDSHAKE: next_st.rdata = {24'h000000, rd_c};
                ppio_pkg::OFS_MODE: next_st.rdata = {24'h000000, st.mode};
                default: next_st.rdata = 32'h00000000;
            endcase
        end
        // Host reads of a strobed input port empty its buffer
        if (take & avs_req.read & ga_m1 & a_in & avs_req.address == ppio_pkg::OFS_PORT_A)
            next_st.port_a_input_full = 1'b0;
        if (take & avs_req.read & gb_m1 & b_in & avs_req.address == ppio_pkg::OFS_PORT_B)
            next_st.port_b_input_full = 1'b0;
        // Host writes
        if (take & avs_req.write & avs_req.byteenable[0]) begin
            unique case (avs_req.address)
                ppio_pkg::OFS_PORT_A: begin
                    next_st.lat_a = avs_req.writedata[7:0];
                    if (ga_m1 & ~a_in)
                        next_st.port_a_output_full_n = 1'b0;
                end
                ppio_pkg::OFS_PORT_B: begin
                    next_st.lat_b = avs_req.writedata[7:0];
                    if (gb_m1 & ~b_in)
                        next_st.port_b_output_full_n = 1'b0;
                end
                ppio_pkg::OFS_HANDSHAKE: next_st.lat_c = avs_req.writedata[7:0];
                ppio_pkg::OFS_MODE: begin
                    if (avs_req.writedata[ppio_pkg::MW_FLAG]) begin
                        next_st.mode = avs_req.writedata[7:0];
                        next_st.lat_a = 8'h00;
                        next_st.lat_b = 8'h00;
                        next_st.lat_c = 8'h00;
                        next_st.port_a_input_full = 1'b0;
                        next_st.port_b_input_full = 1'b0;
                        next_st.port_a_output_full_n = 1'b1;
                        next_st.port_b_output_full_n = 1'b1;
                    end
                end
                default: next_st.mode = st.mode;
            endcase
        end
        // Peripheral events win over host clears
        if (fall_stb_a) begin
            next_st.in_a = st.s2_a;
            next_st.port_a_input_full = 1'b1;
        end
        if (fall_stb_b) begin
            next_st.in_b = st.s2_b;
            next_st.port_b_input_full = 1'b1;
        end
        if (fall_ack_a)
            next_st.port_a_output_full_n = 1'b1;
        if (fall_ack_b)
            next_st.port_b_output_full_n = 1'b1;
        // Pin drivers
        next_st.pa_out = st.lat_a;
        next_st.pa_oe = {8{~a_in}};
        next_st.pb_out = st.lat_b;
        next_st.pb_oe = {8{~b_in}};
        next_st.pc_out = (drv_mask & stat) | (~drv_mask & st.lat_c);
        next_st.pc_oe = drv_mask | (~hs_mask & ~gp_in);
    end

    // State register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
            st.mode <= ppio_pkg::MODE_RESET;
            st.port_a_output_full_n <= 1'b1;
            st.port_b_output_full_n <= 1'b1;
            st.waitreq <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    always_comb begin
        avs_readdata = st.rdata;
        avs_waitrequest = st.waitreq;
        pa_out = st.pa_out;
        pa_oe = st.pa_oe;
        pb_out = st.pb_out;
        pb_oe = st.pb_oe;
        pc_out = st.pc_out;
        pc_oe = st.pc_oe;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_all_out_drive: assert property (st.mode == ppio_pkg::CW_ALL_OUT |=>
        st.pa_oe == 8'hFF && st.pb_oe == 8'hFF && st.pc_oe == 8'hFF)
        else $error("all-output word does not drive all ports");
    a_a_in_dirs: assert property (st.mode == ppio_pkg::CW_A_IN |=>
        st.pa_oe == 8'h00 && st.pb_oe == 8'hFF && st.pc_oe == 8'hFF)
        else $error("port A input word wrong directions");
    a_b_in_dirs: assert property (st.mode == ppio_pkg::CW_B_IN |=>
        st.pb_oe == 8'h00 && st.pa_oe == 8'hFF)
        else $error("port B input word wrong directions");
    a_c_in_dirs: assert property (st.mode == ppio_pkg::CW_C_IN |=>
        st.pc_oe == 8'h00 && st.pa_oe == 8'hFF)
        else $error("port C input word wrong directions");
    a_strobe_a_full: assert property (fall_stb_a |=>
        st.port_a_input_full && st.in_a == $past(st.s2_a))
        else $error("strobe A did not latch and set full");
    a_strobe_b_full: assert property (fall_stb_b |=>
        st.port_b_input_full && st.in_b == $past(st.s2_b))
        else $error("strobe B did not latch and set full");
    a_spare_a_lines: assert property (st.mode == ppio_pkg::CW_A_STB_IN |=>
        st.pc_oe[7:6] == 2'h3 && st.pc_oe[4] == 1'b0)
        else $error("spare lines 6,7 not free in strobed input");
    a_irq_a_level: assert property (st.mode == ppio_pkg::CW_A_STB_IN |=>
        st.pc_out[3] == $past(st.port_a_input_full & st.lat_c[4]))
        else $error("group A request not enable and full");
    a_write_obf_low: assert property (take && avs_req.write && avs_req.byteenable[0]
        && avs_req.address == ppio_pkg::OFS_PORT_A && st.mode == ppio_pkg::CW_A_STB_OUT
        && !fall_ack_a |=> !st.port_a_output_full_n ##2 !st.pc_out[7])
        else $error("port A write did not lower output full");
    a_bus_wait: assert property (req && st.waitreq |=> !st.waitreq ##1 st.waitreq)
        else $error("waitrequest not released for exactly one cycle");

    c_strobe_in: cover property (fall_stb_a ##[1:20] take && avs_req.read);
    c_ack_out: cover property (!st.port_b_output_full_n ##[1:50] fall_ack_b);
    c_mode_write: cover property (take && avs_req.write && avs_req.address == ppio_pkg::OFS_MODE);
endmodule
`default_nettype wire

//--- test/periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module periph_model (
    input wire logic mclk,
    input wire logic [7:0] pc_pin,
    output logic [7:0] a_drv,
    output logic [7:0] b_drv,
    output logic [7:0] c_drv
);
    // Idle: handshake lines high
    initial begin
        a_drv = 8'h00;
        b_drv = 8'h00;
        c_drv = 8'hFF;
    end
    // Plain pin level on one port
    task automatic put(input int p, input logic [7:0] v);
        @(posedge mclk);
        if (p == 0) a_drv <= v;
        else if (p == 1) b_drv <= v;
        else c_drv <= v;
        // Let the two-flop synchroniser settle before the host looks
        repeat (2) @(posedge mclk);
    endtask
    // Bounded wait for a handshake line level, sampled away from the edge
    task automatic wait_line(input int n, input logic v);
        for (int i = 0; i < 50 && pc_pin[n] !== v; i++) @(negedge mclk);
    endtask
    // Low four cycles, then high four
    task automatic pulse(input int ln);
        @(posedge mclk);
        c_drv[ln] <= 1'b0;
        repeat (4) @(posedge mclk);
        c_drv[ln] <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask
    // Load data once the latch is empty, then drive the complement on the data lines
    task automatic strobe(input bit gb, input logic [7:0] d);
        wait_line(gb ? 1 : 5, 1'b0);
        @(posedge mclk);
        if (gb) b_drv <= d; else a_drv <= d;
        pulse(gb ? 2 : 4);
        if (gb) b_drv <= ~d; else a_drv <= ~d;
    endtask
    // Accept data once output-full goes low
    task automatic ack(input bit gb);
        wait_line(gb ? 1 : 7, 1'b0);
        pulse(gb ? 2 : 6);
    endtask
endmodule
`default_nettype wire

//--- test/strobed_parallel_io_ports_tb.sv
`timescale 1ns/1ps
`default_nettype none
module strobed_parallel_io_ports_tb;
    logic mclk, rstn;
    ppio_pkg::avs_req_t avs_req;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest;
    logic [7:0] pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, pc_in, pc_out, pc_oe;
    logic [7:0] a_drv, b_drv, c_drv;
    int error_cnt = 0;
    int tests_run = 0;

    // Pin level: design where enabled, else peripheral
    assign pa_in = (pa_oe & pa_out) | (~pa_oe & a_drv);
    assign pb_in = (pb_oe & pb_out) | (~pb_oe & b_drv);
    assign pc_in = (pc_oe & pc_out) | (~pc_oe & c_drv);

    strobed_parallel_io_ports u_strobed_parallel_io_ports (
        .mclk(mclk), .rstn(rstn), .avs_req(avs_req), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
        .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .pc_in(pc_in), .pc_out(pc_out),
        .pc_oe(pc_oe)
    );
    periph_model u_periph_model (
        .mclk(mclk), .pc_pin(pc_in), .a_drv(a_drv), .b_drv(b_drv), .c_drv(c_drv)
    );

    ////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One bus cycle; read data lands in rd
    task automatic bus(input logic wr, input logic [3:0] adr, input logic [7:0] wd);
        int i;
        @(posedge mclk);
        avs_req <= '{read: !wr, write: wr, address: adr, writedata: {24'h0, wd},
                     byteenable: 4'hF};
        i = 0;
        do begin
            @(negedge mclk);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 50);
        if (i >= 50) check("waitrequest", 1'b1, 1'b0);
        // Registered read data stands unchanged through the accepting edge
        rd = avs_readdata;
        @(posedge mclk);
        avs_req.read <= 1'b0;
        avs_req.write <= 1'b0;
        @(negedge mclk);
    endtask

    // Bounded wait for a port C output level, sampled away from the edge
    task automatic wait_pc(input int n, input logic v);
        @(negedge mclk);
        for (int i = 0; i < 50 && pc_out[n] !== v; i++) @(negedge mclk);
    endtask

    ////////////////////////////////////////////////////////////////
    // Mode 0 words: directions, latched outputs, live inputs
    task automatic t_mode0();
        logic [7:0] w[4] = '{8'h80, 8'h90, 8'h82, 8'h89};
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, 4'hC, w[k]);
            bus(1'b1, 4'h0, 8'h3C);
            repeat (2) @(negedge mclk);
            check("oe", {pa_oe, pb_oe, pc_oe}, {w[k][4] ? 8'h00 : 8'hFF,
                w[k][1] ? 8'h00 : 8'hFF, w[k][3] ? 4'h0 : 4'hF, w[k][0] ? 4'h0 : 4'hF});
            if (!w[k][4]) check("pa_out", pa_out, 8'h3C);
            if (k > 0) begin
                u_periph_model.put(k - 1, 8'hA5);
                bus(1'b0, 4'((k - 1) * 4), 8'h00);
                check("live in", rd, 8'hA5);
                u_periph_model.put(k - 1, 8'h5A);
                bus(1'b0, 4'((k - 1) * 4), 8'h00);
                check("live in", rd, 8'h5A);
            end
        end
        u_periph_model.put(2, 8'hFF);
        bus(1'b1, 4'hC, 8'h00);
        repeat (2) @(negedge mclk);
        check("oe kept", {pa_oe, pc_oe}, 16'hFF00);
        bus(1'b0, 4'hC, 8'h00);
        check("mode kept", rd, 8'h89);
        bus(1'b0, 4'h1, 8'h00);
        check("misaligned", rd, 32'h0);
    endtask

    // Strobed input on group A or B
    task automatic t_strobe_in(input bit gb);
        bus(1'b1, 4'hC, gb ? 8'h86 : 8'hB0);
        bus(1'b1, 4'h8, gb ? 8'h04 : 8'h10);
        check("strobe oe", pc_oe[gb ? 2 : 4], 1'b0);
        if (!gb) check("free oe", pc_oe[7:6], 2'b11);
        u_periph_model.strobe(gb, gb ? 8'h3C : 8'hC3);
        wait_pc(gb ? 1 : 5, 1'b1);
        check("full pin", pc_out[gb ? 1 : 5], 1'b1);
        check("irq pin", pc_out[gb ? 0 : 3], 1'b1);
        bus(1'b0, 4'h8, 8'h00);
        check("status", rd, gb ? 8'h07 : 8'h38);
        bus(1'b0, gb ? 4'h4 : 4'h0, 8'h00);
        check("latched", rd, gb ? 8'h3C : 8'hC3);
        bus(1'b1, 4'h8, 8'h00);
        bus(1'b0, 4'h8, 8'h00);
        check("status", rd, 8'h00);
    endtask

    // Strobed output on group A or B
    task automatic t_strobe_out(input bit gb);
        bus(1'b1, 4'hC, gb ? 8'h84 : 8'hA0);
        bus(1'b1, 4'h8, gb ? 8'h04 : 8'h40);
        check("ack oe", pc_oe[gb ? 2 : 6], 1'b0);
        if (!gb) check("free oe", pc_oe[5:4], 2'b11);
        bus(1'b1, gb ? 4'h4 : 4'h0, 8'h96);
        wait_pc(gb ? 1 : 7, 1'b0);
        check("full_n", pc_out[gb ? 1 : 7], 1'b0);
        check("data", gb ? pb_out : pa_out, 8'h96);
        bus(1'b0, 4'h8, 8'h00);
        check("status", rd, gb ? 8'h04 : 8'h40);
        u_periph_model.ack(gb);
        wait_pc(gb ? 1 : 7, 1'b1);
        bus(1'b0, 4'h8, 8'h00);
        check("status", rd, gb ? 8'h07 : 8'hC8);
        bus(1'b1, 4'h8, 8'h00);
        bus(1'b0, 4'h8, 8'h00);
        check("status", rd, gb ? 8'h02 : 8'h80);
    endtask

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        avs_req = '0;
        rstn = 1'b0;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        @(negedge mclk);
        check("oe at reset", {pa_oe, pb_oe, pc_oe}, 24'h0);
        t_mode0();
        t_strobe_in(1'b0);
        t_strobe_in(1'b1);
        t_strobe_out(1'b0);
        t_strobe_out(1'b1);
        end_of_test();
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        end_of_test();
    end
endmodule
`default_nettype wire
